// [inc/dip_pkg.sv]
package dip_pkg;

  // Source indices, highest priority first
  localparam int NSRC = 12;
  localparam int SRC_PWD  = 0;
  localparam int SRC_PROG = 1;
  localparam int SRC_LV1  = 2;
  localparam int SRC_LV0  = 3;
  localparam int SRC_ATX  = 4;
  localparam int SRC_ARX  = 5;
  localparam int SRC_EDGE = 6;
  localparam int SRC_DMA  = 7;
  localparam int SRC_BTX  = 8;
  localparam int SRC_BRX  = 9;
  localparam int SRC_TMR  = 10;
  localparam int SRC_SOFT = 11;

  localparam logic [13:0] VEC_RESET = 14'h0000;
  localparam logic [13:0] VEC_PWD   = 14'h002c;
  localparam logic [13:0] VEC_PROG  = 14'h0004;
  localparam logic [13:0] VEC_LV1   = 14'h0008;
  localparam logic [13:0] VEC_LV0   = 14'h000c;
  localparam logic [13:0] VEC_ATX   = 14'h0010;
  localparam logic [13:0] VEC_ARX   = 14'h0014;
  localparam logic [13:0] VEC_EDGE  = 14'h0018;
  localparam logic [13:0] VEC_DMA   = 14'h001c;
  localparam logic [13:0] VEC_BTX   = 14'h0020;
  localparam logic [13:0] VEC_BRX   = 14'h0024;
  localparam logic [13:0] VEC_TMR   = 14'h0028;
  localparam logic [13:0] VEC_SOFT  = 14'h0030;

  // Register offsets
  localparam logic [3:0] ADDR_MASK   = 4'h0;
  localparam logic [3:0] ADDR_CNTL   = 4'h1;
  localparam logic [3:0] ADDR_FC     = 4'h2;
  localparam logic [3:0] ADDR_GLOBAL = 4'h3;
  localparam logic [3:0] ADDR_STAT   = 4'h4;
  localparam logic [3:0] ADDR_MODE   = 4'h5;
  localparam logic [3:0] ADDR_IST    = 4'h6;
  localparam logic [3:0] ADDR_ICLR   = 4'h7;
  localparam logic [3:0] ADDR_IEN    = 4'h8;
  localparam logic [3:0] ADDR_DEPTH  = 4'h9;

  // Control register fields
  localparam int CNTL_SENSE0 = 0;
  localparam int CNTL_SENSE1 = 1;
  localparam int CNTL_SENSE2 = 2;
  localparam int CNTL_NEST   = 4;
  localparam int CNTL_BORROW = 5;

  // Force/clear register: bits 11:0 force, bits 27:16 clear
  localparam int FC_CLR_LSB = 16;

  localparam logic [11:0] MASK_RST  = 12'h000;
  localparam logic [7:0]  MODE_RST  = 8'h00;
  localparam int STACK_DEPTH = 12;

  // Status bits of the event interrupt register
  localparam int EV_TAKEN = 0;
  localparam int EV_OVF   = 1;
  localparam int EV_UNF   = 2;
  localparam int NEV      = 3;

  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } dip_bus_t;

  typedef struct packed {
    logic        valid;
    logic [13:0] vector;
    logic [3:0]  source;
  } dip_vec_t;

endpackage

// [design/dip_top.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - Four request pins, plus two borrowed inputs when port b is reconfigured.
// - Timer, byte DMA, both serial ports, software and power-down also request.
// - Fixed priority; each level maskable except power-down and reset.
// - Programmable pin and two borrowed inputs select edge or level.
// - Both level pins are always level-sensitive.
// - Edge pin is always edge-sensitive; software may force or clear it.
// - Vector table: reset at zero, then priority order, but power-down sits after timer; software last.
// - Port b transmit/borrowed one and receive/borrowed zero share two slots.
// - Routines run nested or strictly one after another.
// - Pending requests ANDed with mask; highest remaining one is served.
// - One cycle after a mask write, all interrupts are held off.
// - Control register picks nesting and sensing of the three programmable inputs.
// - Write-only force/clear register sets or clears requests; reads zero.
// - Status pushed on entry, popped on exit, twelve levels shared.
// - Global on/off gates all servicing including power-down.
// - After reset, global servicing is enabled.
// - Reset masks all, empties the stack and clears mode status.
// - Power-down request is edge-sensitive and never masked.
module dip_top
  import dip_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Register port
  input  wire dip_bus_t    bus,
  output logic [31:0]      rdata,
  // Request pins, active low
  input  wire logic        prog_ext_request_n,
  input  wire logic        level_request_zero_n,
  input  wire logic        level_request_one_n,
  input  wire logic        edge_request_n,
  input  wire logic        borrowed_request_zero_n,
  input  wire logic        borrowed_request_one_n,
  input  wire logic        powerdown_pin_n,
  // Internal event pulses
  input  wire logic        timer_evt,
  input  wire logic        dma_evt,
  input  wire logic        port_a_tx_evt,
  input  wire logic        port_a_rx_evt,
  input  wire logic        port_b_tx_evt,
  input  wire logic        port_b_rx_evt,
  // Sequencer side
  input  wire logic        int_ack,
  input  wire logic        int_return,
  input  wire logic        global_int_on,
  input  wire logic        global_int_off,
  input  wire logic [7:0]  status_in,
  output dip_vec_t         vec,
  output logic [7:0]       status_out,
  output logic             irq
);

  localparam int EXT = 7;
  localparam int DW  = $clog2(DEPTH + 1);

  logic [EXT-1:0] pin_a_r, pin_b_r, pin_c_r;
  logic [EXT-1:0] pin_raw, act, act_prev_r, fall;
  logic [11:0] mask_r, pend, edge_lat_r, fc_set, fc_clr, ack_clr, live;
  logic [5:0]  cntl_r;
  logic        glob_r, mask_hold_r;
  logic [7:0]  mode_r;
  logic [7:0]  stack_r [DEPTH];
  logic [DW-1:0] sp_r;
  logic [11:0] act_lvl_r;
  logic [NEV-1:0] ist_r, ien_r, ev;
  logic [3:0]  win;
  logic        win_ok;
  logic [13:0] win_vec;
  logic        push, pop;
  logic        wr_mask, wr_fc;

  assign pin_raw = {powerdown_pin_n, borrowed_request_one_n,
                    borrowed_request_zero_n, edge_request_n,
                    level_request_one_n, level_request_zero_n,
                    prog_ext_request_n};

  // Three-stage pin synchroniser; a change counts when stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_a_r <= '1;
      pin_b_r <= '1;
      pin_c_r <= '1;
    end else begin
      pin_a_r <= pin_raw;
      pin_b_r <= pin_a_r;
      pin_c_r <= pin_b_r;
    end
  end

  always_comb begin
    for (int i = 0; i < EXT; i++)
      act[i] = (pin_b_r[i] == pin_c_r[i]) ? ~pin_c_r[i] : act_prev_r[i];
  end

  always_ff @(posedge ref_clk) begin
    if (rst) act_prev_r <= '0;
    else     act_prev_r <= act;
  end

  assign fall = act & ~act_prev_r;
  assign wr_mask = bus.wr && bus.addr == ADDR_MASK;
  assign wr_fc   = bus.wr && bus.addr == ADDR_FC;
  assign fc_set  = wr_fc ? bus.wdata[11:0] : '0;
  assign fc_clr  = wr_fc ? bus.wdata[FC_CLR_LSB +: 12] : '0;

  // Edge-sensing sources latch; the port b slots carry their serial events unless CNTL_BORROW is set
  logic [11:0] edge_in, is_edge;
  always_comb begin
    edge_in = '0;
    is_edge = '0;
    edge_in[SRC_PWD]  = fall[6];
    is_edge[SRC_PWD]  = 1'b1;
    edge_in[SRC_EDGE] = fall[3];
    is_edge[SRC_EDGE] = 1'b1;
    edge_in[SRC_PROG] = fall[0];
    is_edge[SRC_PROG] = cntl_r[CNTL_SENSE2];
    is_edge[SRC_BRX]  = ~cntl_r[CNTL_BORROW] | cntl_r[CNTL_SENSE0];
    is_edge[SRC_BTX]  = ~cntl_r[CNTL_BORROW] | cntl_r[CNTL_SENSE1];
    edge_in[SRC_BRX]  = cntl_r[CNTL_BORROW] ? fall[4] : port_b_rx_evt;
    edge_in[SRC_BTX]  = cntl_r[CNTL_BORROW] ? fall[5] : port_b_tx_evt;
    edge_in[SRC_TMR]  = timer_evt;
    edge_in[SRC_DMA]  = dma_evt;
    edge_in[SRC_ATX]  = port_a_tx_evt;
    edge_in[SRC_ARX]  = port_a_rx_evt;
    is_edge[SRC_TMR]  = 1'b1;
    is_edge[SRC_DMA]  = 1'b1;
    is_edge[SRC_ATX]  = 1'b1;
    is_edge[SRC_ARX]  = 1'b1;
    is_edge[SRC_SOFT] = 1'b1;
  end

  assign ack_clr = (vec.valid && int_ack) ? (12'h001 << vec.source) : '0;

  // Latched requests: set wins over clear; cleared on entry or by software
  always_ff @(posedge ref_clk) begin
    if (rst) edge_lat_r <= '0;
    else edge_lat_r <= ((edge_lat_r & ~fc_clr & ~ack_clr) | edge_in | fc_set)
                       & is_edge;
  end

  always_comb begin
    pend = edge_lat_r;
    pend[SRC_LV0]  = act[1];
    pend[SRC_LV1]  = act[2];
    if (!cntl_r[CNTL_SENSE2]) pend[SRC_PROG] = act[0];
    if (cntl_r[CNTL_BORROW] && !cntl_r[CNTL_SENSE0])
      pend[SRC_BRX] = act[4];
    if (cntl_r[CNTL_BORROW] && !cntl_r[CNTL_SENSE1])
      pend[SRC_BTX] = act[5];
  end

  // Mask AND, nesting filter and fixed-priority pick
  always_comb begin
    live = pend & (mask_r | 12'h001);
    if (mask_hold_r) live = '0;
    if (!glob_r) live = '0;
    if (sp_r != '0) begin
      if (!cntl_r[CNTL_NEST]) live = '0;
      else live = live & ~act_lvl_r & ((act_lvl_r & -act_lvl_r) - 12'h001);
    end
    win = 4'h0;
    win_ok = 1'b0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (live[i]) begin
        win = i[3:0];
        win_ok = 1'b1;
      end
    end
  end

  always_comb begin
    case (win)
      4'd0:    win_vec = VEC_PWD;
      4'd1:    win_vec = VEC_PROG;
      4'd2:    win_vec = VEC_LV1;
      4'd3:    win_vec = VEC_LV0;
      4'd4:    win_vec = VEC_ATX;
      4'd5:    win_vec = VEC_ARX;
      4'd6:    win_vec = VEC_EDGE;
      4'd7:    win_vec = VEC_DMA;
      4'd8:    win_vec = VEC_BTX;
      4'd9:    win_vec = VEC_BRX;
      4'd10:   win_vec = VEC_TMR;
      4'd11:   win_vec = VEC_SOFT;
      default: win_vec = VEC_RESET;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) vec <= '0;
    else begin
      vec.valid  <= win_ok && !(vec.valid && int_ack);
      vec.vector <= win_vec;
      vec.source <= win;
    end
  end

  assign push = vec.valid && int_ack && sp_r < DW'(DEPTH);
  assign pop  = int_return && sp_r != '0;

  // Status stack and active-level tracking
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sp_r      <= '0;
      act_lvl_r <= '0;
    end else if (push) begin
      stack_r[sp_r] <= status_in;
      sp_r          <= sp_r + DW'(1);
      act_lvl_r     <= act_lvl_r | (12'h001 << vec.source);
    end else if (pop) begin
      sp_r      <= sp_r - DW'(1);
      act_lvl_r <= act_lvl_r & (act_lvl_r - 12'h001);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) status_out <= '0;
    else if (pop) status_out <= stack_r[sp_r - DW'(1)];
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mask_r      <= MASK_RST;
      mask_hold_r <= 1'b0;
      cntl_r      <= '0;
      mode_r      <= MODE_RST;
    end else begin
      mask_hold_r <= wr_mask;
      if (wr_mask) mask_r <= bus.wdata[11:0];
      if (bus.wr && bus.addr == ADDR_CNTL) cntl_r <= bus.wdata[5:0];
      if (bus.wr && bus.addr == ADDR_MODE) mode_r <= bus.wdata[7:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) glob_r <= 1'b1;
    else if (global_int_off) glob_r <= 1'b0;
    else if (global_int_on) glob_r <= 1'b1;
    else if (bus.wr && bus.addr == ADDR_GLOBAL) glob_r <= bus.wdata[0];
  end

  // Event interrupt: taken, stack overflow, stack underflow
  assign ev[EV_TAKEN] = push;
  assign ev[EV_OVF]   = vec.valid && int_ack && sp_r == DW'(DEPTH);
  assign ev[EV_UNF]   = int_return && sp_r == '0;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ist_r <= '0;
      ien_r <= '0;
      irq   <= 1'b0;
    end else begin
      ist_r <= (ist_r & ~((bus.wr && bus.addr == ADDR_ICLR)
                ? bus.wdata[NEV-1:0] : '0)) | ev;
      if (bus.wr && bus.addr == ADDR_IEN) ien_r <= bus.wdata[NEV-1:0];
      irq <= |(ist_r & ien_r);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) rdata <= '0;
    else if (bus.rd) begin
      case (bus.addr)
        ADDR_MASK:   rdata <= {20'h0, mask_r};
        ADDR_CNTL:   rdata <= {26'h0, cntl_r};
        ADDR_GLOBAL: rdata <= {31'h0, glob_r};
        ADDR_STAT:   rdata <= {8'h0, act_lvl_r, pend};
        ADDR_MODE:   rdata <= {24'h0, mode_r};
        ADDR_IST:    rdata <= {29'h0, ist_r};
        ADDR_IEN:    rdata <= {29'h0, ien_r};
        ADDR_DEPTH:  rdata <= 32'(sp_r);
        default:     rdata <= '0;
      endcase
    end else rdata <= '0;
  end

  // Checks
  property p_hold;
    @(posedge ref_clk) disable iff (rst) wr_mask |=> !win_ok;
  endproperty
  a_hold: assert property (p_hold) else $error("mask hold missed");

  property p_glob;
    @(posedge ref_clk) disable iff (rst) !glob_r |-> ##1 !vec.valid;
  endproperty
  a_glob: assert property (p_glob) else $error("served while off");

  property p_pwd;
    @(posedge ref_clk) disable iff (rst)
      vec.valid && vec.source == 4'd0 |-> vec.vector == VEC_PWD;
  endproperty
  a_pwd: assert property (p_pwd) else $error("bad pwd vector");

  property p_tmr;
    @(posedge ref_clk) disable iff (rst)
      vec.valid && vec.source == 4'd10 |-> vec.vector == VEC_TMR;
  endproperty
  a_tmr: assert property (p_tmr) else $error("bad timer vector");

  property p_fc;
    @(posedge ref_clk) disable iff (rst)
      wr_fc && bus.wdata[SRC_EDGE] |=> edge_lat_r[SRC_EDGE];
  endproperty
  a_fc: assert property (p_fc) else $error("force lost");

  property p_stack;
    @(posedge ref_clk) disable iff (rst) push |=> sp_r == $past(sp_r) + 1;
  endproperty
  a_stack: assert property (p_stack) else $error("push lost");

  property p_seq;
    @(posedge ref_clk) disable iff (rst)
      sp_r != '0 && !cntl_r[CNTL_NEST] |-> !win_ok;
  endproperty
  a_seq: assert property (p_seq) else $error("nested in seq mode");

  property p_latch;
    @(posedge ref_clk) disable iff (rst)
      edge_lat_r[SRC_EDGE] && !ack_clr[SRC_EDGE] && !fc_clr[SRC_EDGE]
      |=> edge_lat_r[SRC_EDGE];
  endproperty
  a_latch: assert property (p_latch) else $error("edge dropped");

  c_taken: cover property (@(posedge ref_clk) push);
  c_nest:  cover property (@(posedge ref_clk) push && sp_r == DW'(1));
  c_pop:   cover property (@(posedge ref_clk) pop);

endmodule

// [sim/dip_seq_model.sv]
`timescale 1ns/1ps
module dip_seq_model
  import dip_pkg::*;
(
  // Clock and reset
  input  wire logic     ref_clk,
  input  wire logic     rst,
  // Vector side
  input  wire dip_vec_t vec,
  input  wire logic     slow,
  output logic          int_ack,
  output logic          int_return
);
  int wait_r;
  int svc_r;

  // Takes one vector, runs its routine for eight cycles, then returns
  always_ff @(posedge ref_clk) begin
    int_ack <= 1'b0;
    int_return <= 1'b0;
    if (rst) begin
      wait_r <= 0;
      svc_r <= 0;
    end else if (svc_r > 0) begin
      svc_r <= svc_r - 1;
      int_return <= (svc_r == 1);
    end else if (vec.valid) begin
      if (wait_r >= (slow ? 5 : 0)) begin
        int_ack <= 1'b1;
        wait_r <= 0;
        svc_r <= 8;
      end else begin
        wait_r <= wait_r + 1;
      end
    end else begin
      wait_r <= 0;
    end
  end
endmodule

// [sim/dip_top_tb.sv]
`timescale 1ns/1ps
module dip_top_tb
  import dip_pkg::*;
();
  logic        ref_clk = 1'b0;
  logic        rst;
  dip_bus_t    bus;
  logic [31:0] rdata;
  logic        prog_n, lv0_n, lv1_n, edge_n, bz_n, bo_n, pwd_n;
  logic        tmr, dma, atx, arx, btx, brx;
  logic        int_ack, int_return, g_on, g_off, slow, irq;
  logic [7:0]  status_in, status_out;
  dip_vec_t    vec;
  logic [31:0] rq[$];
  logic [13:0] vq[$];
  logic [7:0]  sq[$];
  logic        rd_d, ret_d;
  int          err_count, num_checks, acks;
  int          seed = 73;

  dip_top dip_top_i (.ref_clk(ref_clk), .rst(rst), .bus(bus),
    .rdata(rdata), .prog_ext_request_n(prog_n),
    .level_request_zero_n(lv0_n), .level_request_one_n(lv1_n),
    .edge_request_n(edge_n), .borrowed_request_zero_n(bz_n),
    .borrowed_request_one_n(bo_n), .powerdown_pin_n(pwd_n),
    .timer_evt(tmr), .dma_evt(dma), .port_a_tx_evt(atx),
    .port_a_rx_evt(arx), .port_b_tx_evt(btx), .port_b_rx_evt(brx),
    .int_ack(int_ack), .int_return(int_return), .global_int_on(g_on),
    .global_int_off(g_off), .status_in(status_in), .vec(vec),
    .status_out(status_out), .irq(irq));

  dip_seq_model dip_seq_model_i (.ref_clk(ref_clk), .rst(rst), .vec(vec),
    .slow(slow), .int_ack(int_ack), .int_return(int_return));

  always #5 ref_clk = ~ref_clk;

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic give_verdict();
    if (err_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Watcher: read data, taken vectors and popped status
  always @(posedge ref_clk) begin
    rd_d <= bus.rd;
    ret_d <= int_return;
    status_in <= 8'($random(seed));
    slow <= 1'($random(seed));
    if (rd_d)
      chk("rdata", rq.pop_front(), rdata);
    if (int_ack === 1'b1 && !rst) begin
      acks++;
      sq.push_back(status_in);
      chk("vector", vq.size() ? {18'h1, vq.pop_front()} : 32'hffff_ffff,
          {17'h0, vec.valid, vec.vector});
    end
    if (ret_d)
      chk("status_out", {24'h0, sq.pop_back()}, {24'h0, status_out});
  end

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    rq.push_back(e);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus.rd <= 1'b0;
  endtask

  task automatic wait_acks(input int n);
    int k;
    k = 0;
    while (acks < n && k < 300) begin
      @(posedge ref_clk);
      k++;
    end
    if (acks < n) begin
      err_count++;
      $display("[ERR] acks exp %0d got %0d", n, acks);
      give_verdict();
    end
    // The routine removes a level request before it returns
    lv0_n <= 1'b1;
    idle(12);
  endtask

  initial begin
    bus = '0;
    {prog_n, lv0_n, lv1_n, edge_n, bz_n, bo_n, pwd_n} = 7'h7f;
    {tmr, dma, atx, arx, btx, brx, g_on, g_off} = 8'h00;
    status_in = 8'h00;
    slow = 1'b0;
    rst = 1'b1;
    idle(6);
    rst <= 1'b0;
    rd(ADDR_MASK, 32'h0);
    rd(ADDR_MODE, 32'h0);
    rd(ADDR_DEPTH, 32'h0);
    rd(ADDR_GLOBAL, 32'h1);
    rd(4'hf, 32'h0);
    rd(ADDR_FC, 32'h0);
    // Seven forced sources served one after another by rank
    vq = '{VEC_ATX, VEC_ARX, VEC_EDGE, VEC_DMA, VEC_BTX, VEC_BRX, VEC_TMR};
    wr(ADDR_MASK, 32'h0000_0fff);
    wr(ADDR_FC, 32'h0000_07f0);
    wait_acks(7);
    // A forced then cleared request is never served
    wr(ADDR_MASK, 32'h0);
    wr(ADDR_FC, 32'h0000_0400);
    wr(ADDR_FC, 32'h0400_0000);
    wr(ADDR_MASK, 32'h0000_0400);
    idle(10);
    // Edge seen while masked stays pending
    edge_n <= 1'b0;
    idle(4);
    edge_n <= 1'b1;
    idle(10);
    vq.push_back(VEC_EDGE);
    wr(ADDR_MASK, 32'h0000_0440);
    wait_acks(8);
    vq.push_back(VEC_LV0);
    wr(ADDR_MASK, 32'h0000_0008);
    lv0_n <= 1'b0;
    wait_acks(9);
    idle(12);
    wr(ADDR_CNTL, 32'h0000_0004);
    wr(ADDR_MASK, 32'h0000_0002);
    vq.push_back(VEC_PROG);
    prog_n <= 1'b0;
    idle(3);
    prog_n <= 1'b1;
    wait_acks(10);
    // Power-down ignores the mask but is held off by the global switch
    g_off <= 1'b1;
    idle(1);
    g_off <= 1'b0;
    wr(ADDR_FC, 32'h0000_0001);
    idle(10);
    vq.push_back(VEC_PWD);
    g_on <= 1'b1;
    idle(1);
    g_on <= 1'b0;
    wait_acks(11);
    wr(ADDR_IEN, 32'h1);
    idle(2);
    chk("irq", 32'h1, {31'h0, irq});
    rd(ADDR_IST, 32'h1);
    wr(ADDR_ICLR, 32'h1);
    idle(2);
    chk("irq", 32'h0, {31'h0, irq});
    rd(ADDR_IST, 32'h0);
    idle(3);
    chk("left", 32'h0, vq.size());
    give_verdict();
  end
endmodule
